// [hdl/qsfpl_defs.svh]
`ifndef QSFPL_DEFS_SVH
`define QSFPL_DEFS_SVH

// Command codes carried in the first byte of a frame.
`define QSFPL_CMD_WR1 8'h0A
`define QSFPL_CMD_RD1 8'h0B
`define QSFPL_CMD_WRQ 8'h1A
`define QSFPL_CMD_RDQ 8'h1B

// Last unit index inside one byte, per lane width.
`define QSFPL_X1_LAST 3'h7
`define QSFPL_X4_LAST 3'h1

// Serial clock pulses spent on the command byte.
`define QSFPL_CMD_PULSES 12'h008

// Host divider: system clocks per serial clock half period (160 ns period at 100 MHz).
`define QSFPL_SCLK_HALF 4'h8

// System clocks the host keeps select high between frames.
`define QSFPL_CS_GAP 4'h8

// Lane enable patterns.
`define QSFPL_OE_NONE 4'h0
`define QSFPL_OE_LANE0 4'h1
`define QSFPL_OE_LANE1 4'h2
`define QSFPL_OE_ALL 4'hF

// Level of an undriven lane, as pulled up on the board.
`define QSFPL_LANE_IDLE 1'h1

`endif

// [hdl/qsfpl_pkg.sv]
package qsfpl_pkg;

  // Device operation within a frame; Gray along the listed order, not along command to transfer.
  typedef enum logic [2:0] {
    DEV_CMD  = 3'h0,
    DEV_WR1  = 3'h1,
    DEV_RD1  = 3'h3,
    DEV_WRQ  = 3'h2,
    DEV_RDQ  = 3'h6,
    DEV_NONE = 3'h7
  } qsfpl_op_t;

  // Host frame sequencer.
  typedef enum logic [1:0] {
    HST_IDLE = 2'h0,
    HST_LEAD = 2'h1,
    HST_RUN  = 2'h3,
    HST_GAP  = 2'h2
  } qsfpl_hst_t;

endpackage

// [hdl/qsfpl_link_if.sv]
`timescale 1ns/1ns
`include "qsfpl_defs.svh"

interface qsfpl_link_if;
  logic chipSelectLow;
  logic serialClockIn;
  logic [3:0] hostLaneOut;
  logic [3:0] hostLaneOe;
  logic [3:0] devLaneOut;
  logic [3:0] devLaneOe;
  logic [3:0] ioLane;

  // Undriven lanes float to the pulled-up level.
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign ioLane[i] = hostLaneOe[i] ? hostLaneOut[i] :
                       (devLaneOe[i] ? devLaneOut[i] : `QSFPL_LANE_IDLE);
  end

  modport host (
    output chipSelectLow,
    output serialClockIn,
    output hostLaneOut,
    output hostLaneOe,
    input ioLane
  );

  modport dev (
    input chipSelectLow,
    input serialClockIn,
    input ioLane,
    output devLaneOut,
    output devLaneOe
  );
endinterface // qsfpl_link_if

// [hdl/qsfpl_host_end.sv]
`timescale 1ns/1ns
`include "qsfpl_defs.svh"

module qsfpl_host_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link pins
  qsfpl_link_if.host link,
  // Frame request
  input wire logic startReq,
  input wire logic [7:0] cmdByte,
  input wire logic [7:0] lenBytes,
  output logic busy,
  // Write data
  input wire logic [7:0] wrByte,
  output logic wrTake,
  // Read data
  output logic [7:0] rdByte,
  output logic rdValid
);
  qsfpl_pkg::qsfpl_hst_t state_r, state_nxt;
  logic [3:0] divCnt_r;
  logic [11:0] pulseCnt_r;
  logic [2:0] unitCnt_r;
  logic [7:0] cmd_r, len_r, txShift_r, rdShift_r, rdByte_r;
  logic sclk_r, cs_r, busy_r, wrTake_r, rdValid_r;
  logic [3:0] laneOut_r, laneOe_r, laneMeta_r, laneSync_r;

  wire stIdle = state_r == qsfpl_pkg::HST_IDLE;
  wire stRun = state_r == qsfpl_pkg::HST_RUN;
  wire tick = divCnt_r == (`QSFPL_SCLK_HALF - 4'h1);
  wire gapDone = divCnt_r == (`QSFPL_CS_GAP - 4'h1);
  wire startNow = stIdle && startReq;
  wire isQuad = cmd_r == `QSFPL_CMD_WRQ || cmd_r == `QSFPL_CMD_RDQ;
  wire isRead = cmd_r == `QSFPL_CMD_RD1 || cmd_r == `QSFPL_CMD_RDQ;
  wire isWrite = cmd_r == `QSFPL_CMD_WR1 || cmd_r == `QSFPL_CMD_WRQ;
  wire [11:0] pulseTotal = `QSFPL_CMD_PULSES +
                           (isQuad ? {3'h0, len_r, 1'h0} : {1'h0, len_r, 3'h0});
  // Host owns the serial clock; edges come from the divider.
  // host drives clock
  wire riseNow = stRun && tick && !sclk_r;
  wire fallNow = stRun && tick && sclk_r;
  wire [11:0] pulseDone = pulseCnt_r + 12'h001;
  wire lastPulse = pulseDone == pulseTotal;
  wire inData = pulseDone >= `QSFPL_CMD_PULSES;
  wire dataFall = fallNow && pulseDone > `QSFPL_CMD_PULSES;
  wire unitLast = isQuad ? unitCnt_r == `QSFPL_X4_LAST : unitCnt_r == `QSFPL_X1_LAST;
  wire sampleNow = dataFall && isRead;
  wire loadWr = fallNow && isWrite && !lastPulse &&
                (pulseDone == `QSFPL_CMD_PULSES || (dataFall && unitLast));
  wire quadStep = isQuad && pulseDone > `QSFPL_CMD_PULSES;
  wire [7:0] stepShift = quadStep ? {txShift_r[3:0], 4'h0} : {txShift_r[6:0], 1'h0};
  wire [7:0] shiftBase = loadWr ? wrByte : stepShift;
  wire driveQuad = isQuad && isWrite && inData;
  wire [3:0] laneOutFall = driveQuad ? shiftBase[7:4] : {3'h0, shiftBase[7]};
  wire [3:0] laneOeFall = lastPulse ? `QSFPL_OE_NONE :
                          (!inData ? `QSFPL_OE_LANE0 :
                          (isRead ? `QSFPL_OE_NONE :
                          (driveQuad ? `QSFPL_OE_ALL : `QSFPL_OE_LANE0)));
  wire [7:0] rdShiftNext = isQuad ? {rdShift_r[3:0], laneSync_r} :
                           {rdShift_r[6:0], laneSync_r[1]};

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      qsfpl_pkg::HST_IDLE: if (startReq) state_nxt = qsfpl_pkg::HST_LEAD;
      qsfpl_pkg::HST_LEAD: if (tick) state_nxt = qsfpl_pkg::HST_RUN;
      qsfpl_pkg::HST_RUN: if (fallNow && lastPulse) state_nxt = qsfpl_pkg::HST_GAP;
      qsfpl_pkg::HST_GAP: if (gapDone) state_nxt = qsfpl_pkg::HST_IDLE;
      default: state_nxt = qsfpl_pkg::HST_IDLE;
    endcase
  end

  // Device output arrives from another clock; two flops before use.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      laneMeta_r <= 4'h0;
      laneSync_r <= 4'h0;
    end else begin
      laneMeta_r <= link.ioLane;
      laneSync_r <= laneMeta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= qsfpl_pkg::HST_IDLE;
      divCnt_r <= 4'h0;
      busy_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      divCnt_r <= (state_nxt != state_r || tick || stIdle) ? 4'h0 : divCnt_r + 4'h1;
      busy_r <= state_nxt != qsfpl_pkg::HST_IDLE;
    end
  end

  // Select falls at start and rises after the last pulse, framing each operation.
  // select falls first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_r <= 1'h1;
      sclk_r <= 1'h0;
    end else begin
      cs_r <= startNow ? 1'h0 : ((fallNow && lastPulse) ? 1'h1 : cs_r);
      sclk_r <= riseNow ? 1'h1 : (fallNow ? 1'h0 : sclk_r);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r <= 8'h00;
      len_r <= 8'h00;
      pulseCnt_r <= 12'h000;
      unitCnt_r <= 3'h0;
    end else if (startNow) begin
      cmd_r <= cmdByte;
      len_r <= lenBytes;
      pulseCnt_r <= 12'h000;
      unitCnt_r <= 3'h0;
    end else if (fallNow) begin
      pulseCnt_r <= pulseDone;
      unitCnt_r <= (dataFall && unitLast) ? 3'h0 : (dataFall ? unitCnt_r + 3'h1 : 3'h0);
    end
  end

  // Outputs change at the frame start and after each falling edge, ahead of the next rise.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txShift_r <= 8'h00;
      laneOut_r <= 4'h0;
      laneOe_r <= `QSFPL_OE_NONE;
      wrTake_r <= 1'h0;
    end else begin
      wrTake_r <= loadWr;
      if (startNow) begin
        txShift_r <= cmdByte;
        laneOut_r <= {3'h0, cmdByte[7]};
        laneOe_r <= `QSFPL_OE_LANE0;
      end else if (fallNow) begin
        txShift_r <= shiftBase;
        laneOut_r <= laneOutFall;
        laneOe_r <= laneOeFall;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdShift_r <= 8'h00;
      rdByte_r <= 8'h00;
      rdValid_r <= 1'h0;
    end else begin
      rdValid_r <= sampleNow && unitLast;
      if (sampleNow) rdShift_r <= rdShiftNext;
      if (sampleNow && unitLast) rdByte_r <= rdShiftNext;
    end
  end

  assign link.chipSelectLow = cs_r;
  assign link.serialClockIn = sclk_r;
  assign link.hostLaneOut = laneOut_r;
  assign link.hostLaneOe = laneOe_r;
  assign busy = busy_r;
  assign wrTake = wrTake_r;
  assign rdByte = rdByte_r;
  assign rdValid = rdValid_r;
endmodule // qsfpl_host_end

// [hdl/qsfpl_dev_end.sv]
`timescale 1ns/1ns
`include "qsfpl_defs.svh"

// Overview of operation
// - select high: lanes released, device idle
// - select low: device active, serves operations
// - host gives select fall after power-up
// - host frames each operation with select
// - host clocks; device captures lane 0 rising
// - device changes outputs after falling edges
// - single mode: lane 0 carries write input
// - single mode: lane 1 returns read data
// - quad mode: lane 0 in, or out
// - quad mode: lanes 2, 3 drive reads
// - quad write: all four lanes input
// - quad read: all four lanes output
module qsfpl_dev_end (
  // Power-up reset
  input wire logic rst_b,
  // Link pins
  qsfpl_link_if.dev link,
  // Received data, on the serial clock
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic [7:0] rxCount,
  // Data to send, on the serial clock
  input wire logic [7:0] txByte,
  output logic txTake,
  // Frame status
  output qsfpl_pkg::qsfpl_op_t opMode,
  output logic [7:0] cmdCode,
  output logic badCmd,
  output logic active
);
  qsfpl_pkg::qsfpl_op_t op_r, op_nxt, decodedOp;
  logic armed_r;
  logic [2:0] bitCnt_r;
  logic [7:0] inShift_r;
  logic [7:0] rxByte_r;
  logic rxValid_r;
  logic [7:0] rxCount_r;
  logic [7:0] cmdCode_r;
  logic badCmd_r;
  logic active_r;
  logic [2:0] outCnt_r;
  logic [7:0] outShift_r;
  logic [3:0] laneOut_r;
  logic [3:0] laneOe_r;
  logic txTake_r;

  // Nothing runs until select has fallen once since power-up; a select that
  // is already low at power-up is not a frame start.
  // await select fall
  always_ff @(negedge link.chipSelectLow or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'h0;
    end else begin
      armed_r <= 1'h1;
    end
  end

  // The serial clock may stop with select still low, so select itself
  // clears the frame state instead of waiting for another edge.
  // deselect holds idle
  wire frameRst_b = rst_b & armed_r & ~link.chipSelectLow;

  // The command byte always arrives on lane 0, whatever width follows.
  // enabled when selected
  wire inCapture = op_r == qsfpl_pkg::DEV_CMD || op_r == qsfpl_pkg::DEV_WR1 ||
                   op_r == qsfpl_pkg::DEV_WRQ;
  wire quadIn = op_r == qsfpl_pkg::DEV_WRQ;
  wire writing = op_r == qsfpl_pkg::DEV_WR1 || quadIn;
  wire byteDone = inCapture &&
                  (quadIn ? bitCnt_r == `QSFPL_X4_LAST : bitCnt_r == `QSFPL_X1_LAST);
  wire [7:0] inShiftNext = quadIn ? {inShift_r[3:0], link.ioLane} :
                           {inShift_r[6:0], link.ioLane[0]};
  wire [2:0] bitCntNext = (byteDone || !inCapture) ? 3'h0 : bitCnt_r + 3'h1;

  // An unknown code parks the frame in a state that drives no lane, so a
  // corrupted command can never turn the device into a second driver.
  wire codeWr1 = inShiftNext == `QSFPL_CMD_WR1;
  wire codeRd1 = inShiftNext == `QSFPL_CMD_RD1;
  wire codeWrq = inShiftNext == `QSFPL_CMD_WRQ;
  wire codeRdq = inShiftNext == `QSFPL_CMD_RDQ;
  assign decodedOp = codeWr1 ? qsfpl_pkg::DEV_WR1 :
                     codeRd1 ? qsfpl_pkg::DEV_RD1 :
                     codeWrq ? qsfpl_pkg::DEV_WRQ :
                     codeRdq ? qsfpl_pkg::DEV_RDQ :
                     qsfpl_pkg::DEV_NONE;

  // A frame holds one operation; only a select rise or the power-up reset leaves it.
  always_comb begin
    op_nxt = op_r;
    case (op_r)
      qsfpl_pkg::DEV_CMD: if (byteDone) op_nxt = decodedOp;
      qsfpl_pkg::DEV_WR1: op_nxt = qsfpl_pkg::DEV_WR1;
      qsfpl_pkg::DEV_RD1: op_nxt = qsfpl_pkg::DEV_RD1;
      qsfpl_pkg::DEV_WRQ: op_nxt = qsfpl_pkg::DEV_WRQ;
      qsfpl_pkg::DEV_RDQ: op_nxt = qsfpl_pkg::DEV_RDQ;
      qsfpl_pkg::DEV_NONE: op_nxt = qsfpl_pkg::DEV_NONE;
      default: op_nxt = qsfpl_pkg::DEV_NONE;
    endcase
  end

  // Byte strobes for the rising edge that completes a byte.
  wire cmdDone = op_r == qsfpl_pkg::DEV_CMD && byteDone;
  wire rxDone = writing && byteDone;

  always_ff @(posedge link.serialClockIn or negedge frameRst_b) begin
    if (!frameRst_b) begin
      op_r <= qsfpl_pkg::DEV_CMD;
      bitCnt_r <= 3'h0;
      inShift_r <= 8'h00;
    end else begin
      op_r <= op_nxt;
      bitCnt_r <= bitCntNext;
      inShift_r <= inCapture ? inShiftNext : inShift_r;
    end
  end

  // Each received byte stays readable until the next byte replaces it or the select rise ends the frame.
  always_ff @(posedge link.serialClockIn or negedge frameRst_b) begin
    if (!frameRst_b) begin
      rxByte_r <= 8'h00;
      rxValid_r <= 1'h0;
      rxCount_r <= 8'h00;
    end else begin
      rxValid_r <= rxDone;
      rxByte_r <= rxDone ? inShiftNext : rxByte_r;
      rxCount_r <= rxDone ? rxCount_r + 8'h01 : rxCount_r;
    end
  end

  // Active marks the first rising edge of a frame and clears with select.
  // active mode indication
  always_ff @(posedge link.serialClockIn or negedge frameRst_b) begin
    if (!frameRst_b) begin
      cmdCode_r <= 8'h00;
      badCmd_r <= 1'h0;
      active_r <= 1'h0;
    end else begin
      active_r <= 1'h1;
      cmdCode_r <= cmdDone ? inShiftNext : cmdCode_r;
      badCmd_r <= badCmd_r | (cmdDone && decodedOp == qsfpl_pkg::DEV_NONE);
    end
  end

  // Output side runs on the falling edge so data is stable across the
  // host's sampling edge, the next falling edge a full period later.
  wire readX1 = op_r == qsfpl_pkg::DEV_RD1;
  wire readX4 = op_r == qsfpl_pkg::DEV_RDQ;
  wire reading = readX1 || readX4;
  // The next byte is taken from txByte at the falling edge that starts it, so
  // the user has one byte time after txTake to present the following one; a
  // late update goes out whole in the next byte and is never torn.
  wire loadTx = reading && outCnt_r == 3'h0;
  wire [7:0] curByte = loadTx ? txByte : outShift_r;
  wire outLast = readX4 ? outCnt_r == `QSFPL_X4_LAST : outCnt_r == `QSFPL_X1_LAST;
  wire [2:0] outCntNext = (!reading || outLast) ? 3'h0 : outCnt_r + 3'h1;
  wire [7:0] outShiftNext = readX4 ? {curByte[3:0], 4'h0} : {curByte[6:0], 1'h0};
  // In single-line mode lanes 2 and 3 stay released and rest at the
  // pull-up level that the board holds them at.
  // lane 1 output
  wire [3:0] laneOutNext = readX4 ? curByte[7:4] : {2'h0, curByte[7], 1'h0};
  wire [3:0] laneOeNext = readX4 ? `QSFPL_OE_ALL :
                          (readX1 ? `QSFPL_OE_LANE1 : `QSFPL_OE_NONE);

  // A select rise in the same step as the last falling edge resets these
  // registers after that edge's update, so the lanes always end released.
  // change after fall
  always_ff @(negedge link.serialClockIn or negedge frameRst_b) begin
    if (!frameRst_b) begin
      outCnt_r <= 3'h0;
      outShift_r <= 8'h00;
      laneOut_r <= 4'h0;
      laneOe_r <= `QSFPL_OE_NONE;
      txTake_r <= 1'h0;
    end else begin
      outCnt_r <= outCntNext;
      outShift_r <= reading ? outShiftNext : outShift_r;
      laneOut_r <= laneOutNext;
      laneOe_r <= laneOeNext;
      txTake_r <= loadTx;
    end
  end

  // Every output comes straight from a register of the serial clock domain.
  assign link.devLaneOut = laneOut_r;
  assign link.devLaneOe = laneOe_r;
  assign rxByte = rxByte_r;
  assign rxValid = rxValid_r;
  assign rxCount = rxCount_r;
  assign txTake = txTake_r;
  assign opMode = op_r;
  assign cmdCode = cmdCode_r;
  assign badCmd = badCmd_r;
  assign active = active_r;
endmodule // qsfpl_dev_end

// [verif/qsfpl_link_monitor.sv]
`timescale 1ns/1ns
`include "qsfpl_defs.svh"

module qsfpl_link_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link signals
  input wire logic chipSelectLow,
  input wire logic serialClockIn,
  input wire logic [3:0] hostLaneOut,
  input wire logic [3:0] hostLaneOe,
  input wire logic [3:0] devLaneOut,
  input wire logic [3:0] devLaneOe
);
  logic sclkLast_r;
  logic [7:0] riseCnt_r;
  logic [7:0] riseCnt_nxt;
  wire sclkRise = serialClockIn & ~sclkLast_r;

  // Saturates so that a very long frame cannot wrap back below the command length.
  assign riseCnt_nxt = chipSelectLow ? 8'h00 :
                       riseCnt_r + {7'h00, sclkRise & (riseCnt_r != 8'hFF)};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkLast_r <= 1'h0;
      riseCnt_r <= 8'h00;
    end else begin
      sclkLast_r <= serialClockIn;
      riseCnt_r <= riseCnt_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_lanes_released: assert property (chipSelectLow |-> devLaneOe == `QSFPL_OE_NONE)
    else $error("device drives a lane while deselected");
  a_drive_after_cmd: assert property (devLaneOe != `QSFPL_OE_NONE |-> riseCnt_r >= 8'h08)
    else $error("device drives before the command byte is complete");
  a_change_on_fall: assert property (!chipSelectLow && !$past(chipSelectLow) &&
    !$stable(devLaneOut | devLaneOe) |-> $fell(serialClockIn))
    else $error("device output changed away from a falling clock edge");
  a_lane_roles_legal: assert property (devLaneOe inside {`QSFPL_OE_NONE, `QSFPL_OE_LANE1,
    `QSFPL_OE_ALL})
    else $error("device lane enable pattern is not a read pattern");
  a_no_lane_clash: assert property ((hostLaneOe & devLaneOe) == 4'h0)
    else $error("host and device drive the same lane");
  a_sclk_half: assert property ($rose(serialClockIn) |-> serialClockIn[*8] ##1 !serialClockIn)
    else $error("serial clock high phase is not eight cycles");
  a_sclk_idle_low: assert property (chipSelectLow |-> !serialClockIn)
    else $error("serial clock high outside a frame");
  a_host_data_hold: assert property (serialClockIn && !chipSelectLow |-> $stable(hostLaneOut))
    else $error("host lane data changed while the serial clock is high");
  a_select_gap: assert property ($rose(chipSelectLow) |-> chipSelectLow[*8])
    else $error("select high for fewer than eight cycles");

  c_single_read: cover property (devLaneOe == `QSFPL_OE_LANE1);
  c_quad_read: cover property (devLaneOe == `QSFPL_OE_ALL);
  c_quad_write: cover property (hostLaneOe == `QSFPL_OE_ALL);
endmodule // qsfpl_link_monitor

// [verif/tb_top.sv]
`timescale 1ns/1ns
`include "qsfpl_defs.svh"

module tb_top;
  typedef struct {
    logic [7:0] cmd;
    logic [7:0] len;
    logic [7:0] wr;
    logic [7:0] tx;
    qsfpl_pkg::qsfpl_op_t op;
    logic bad;
    logic [7:0] cnt;
  } qsfpl_row_t;

  logic clk, rst_b, rst2_b, startReq, busy, wrTake, rdValid, rxValid, txTake, badCmd, active;
  logic active2;
  logic [7:0] cmdByte, lenBytes, wrByte, rdByte, rxByte, rxCount, txByte, cmdCode, rxCount2;
  qsfpl_pkg::qsfpl_op_t opMode, opMode2;
  int mismatches, checksDone;
  qsfpl_row_t rows[6] = '{
    '{`QSFPL_CMD_WR1, 8'h01, 8'hA5, 8'h00, qsfpl_pkg::DEV_WR1, 1'h0, 8'h01},
    '{`QSFPL_CMD_WRQ, 8'h02, 8'h3C, 8'h00, qsfpl_pkg::DEV_WRQ, 1'h0, 8'h02},
    '{`QSFPL_CMD_RD1, 8'h01, 8'h00, 8'h96, qsfpl_pkg::DEV_RD1, 1'h0, 8'h00},
    '{`QSFPL_CMD_RDQ, 8'h02, 8'h00, 8'h5A, qsfpl_pkg::DEV_RDQ, 1'h0, 8'h00},
    '{8'h77, 8'h01, 8'h00, 8'h00, qsfpl_pkg::DEV_NONE, 1'h1, 8'h00},
    '{`QSFPL_CMD_WR1, 8'h00, 8'h00, 8'h00, qsfpl_pkg::DEV_WR1, 1'h0, 8'h00}};

  qsfpl_link_if link();
  qsfpl_link_if link2();

  qsfpl_host_end qsfpl_host_end_inst (.clk(clk), .rst_b(rst_b), .link(link),
    .startReq(startReq), .cmdByte(cmdByte), .lenBytes(lenBytes), .busy(busy),
    .wrByte(wrByte), .wrTake(wrTake), .rdByte(rdByte), .rdValid(rdValid));
  qsfpl_dev_end qsfpl_dev_end_inst (.rst_b(rst_b), .link(link), .rxByte(rxByte),
    .rxValid(rxValid), .rxCount(rxCount), .txByte(txByte), .txTake(txTake),
    .opMode(opMode), .cmdCode(cmdCode), .badCmd(badCmd), .active(active));
  // This second device is driven by the bench so that its select can break the power-up order.
  qsfpl_dev_end qsfpl_dev_end_inst2 (.rst_b(rst2_b), .link(link2), .rxByte(), .rxValid(),
    .rxCount(rxCount2), .txByte(8'h00), .txTake(), .opMode(opMode2), .cmdCode(),
    .badCmd(), .active(active2));
  qsfpl_link_monitor qsfpl_link_monitor_inst (.clk(clk), .rst_b(rst_b),
    .chipSelectLow(link.chipSelectLow), .serialClockIn(link.serialClockIn),
    .hostLaneOut(link.hostLaneOut), .hostLaneOe(link.hostLaneOe),
    .devLaneOut(link.devLaneOut), .devLaneOe(link.devLaneOe));

  always #5 clk = ~clk;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrapUp();
    if (mismatches == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic runRow(input qsfpl_row_t r);
    logic [7:0] rx, rd, cnt, cc;
    logic [2:0] op;
    logic bad, isRd, takeLast;
    int n, rdN, wrN, tkN;
    {rx, rd, cnt, cc, op, bad, takeLast, rdN, wrN, tkN} = '0;
    isRd = (r.cmd == `QSFPL_CMD_RD1) || (r.cmd == `QSFPL_CMD_RDQ);
    {cmdByte, lenBytes, wrByte, txByte} = {r.cmd, r.len, r.wr, r.tx};
    startReq = 1'h1;
    @(posedge clk);
    #1 startReq = 1'h0;
    // Device status clears at deselect, so it is caught while the frame is open.
    for (n = 0; n < 3000 && busy === 1'h1; n++) begin
      @(posedge clk);
      #1;
      if (link.chipSelectLow === 1'h0) {op, bad, cnt, cc} = {opMode, badCmd, rxCount, cmdCode};
      if (txTake === 1'h1 && takeLast !== 1'h1) tkN++;
      takeLast = txTake;
      if (rxValid === 1'h1) rx = rxByte;
      if (rdValid === 1'h1) {rd, rdN} = {rdByte, rdN + 1};
      if (wrTake === 1'h1) wrN++;
    end
    if (n == 3000) begin
      mismatches++;
      wrapUp();
    end else begin
      check("opMode", {5'h00, op}, {5'h00, r.op});
      check("badCmd", {7'h00, bad}, {7'h00, r.bad});
      check("rxCount", cnt, r.cnt);
      check("cmdCode", cc, r.cmd);
      if (!r.bad) check("wrTake", 8'(wrN), isRd ? 8'h00 : r.len);
      if (!r.bad) check("rdValid", 8'(rdN), isRd ? r.len : 8'h00);
      if (!isRd && !r.bad && r.len != 8'h00) check("rxByte", rx, r.wr);
      if (isRd) check("rdByte", rd, r.tx);
      if (!r.bad) check("txTake", 8'(tkN), isRd ? r.len : 8'h00);
    end
  endtask

  task automatic frame2(input logic [7:0] c);
    for (int i = 7; i >= 0; i--) begin
      link2.hostLaneOut = {3'h0, c[i]};
      #80 link2.serialClockIn = 1'h1;
      #80 link2.serialClockIn = 1'h0;
    end
  endtask

  initial begin
    {clk, rst_b, rst2_b, startReq, mismatches, checksDone} = '0;
    {cmdByte, lenBytes, wrByte, txByte} = '0;
    {link2.chipSelectLow, link2.serialClockIn, link2.hostLaneOut, link2.hostLaneOe} = 10'h001;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'h1;
    foreach (rows[i]) runRow(rows[i]);
    // A reset in mid-read must drop select and free the lanes at once.
    cmdByte = `QSFPL_CMD_RDQ;
    lenBytes = 8'h02;
    startReq = 1'h1;
    @(posedge clk);
    #1 startReq = 1'h0;
    repeat (150) @(posedge clk);
    #1 rst_b = 1'h0;
    #2 check("select", {7'h00, link.chipSelectLow}, 8'h01);
    check("laneOe", {4'h0, link.devLaneOe}, 8'h00);
    check("active", {7'h00, active}, 8'h00);
    check("busy", {7'h00, busy}, 8'h00);
    repeat (4) @(posedge clk);
    #1 rst_b = 1'h1;
    runRow(rows[0]);
    // Select held low across power-up: the command must be ignored.
    @(posedge clk);
    #1 rst2_b = 1'h1;
    frame2(`QSFPL_CMD_WR1);
    #1 check("active2", {7'h00, active2}, 8'h00);
    check("rxCount2", rxCount2, 8'h00);
    link2.chipSelectLow = 1'h1;
    #160 link2.chipSelectLow = 1'h0;
    #160 frame2(`QSFPL_CMD_WR1);
    #1 check("active2", {7'h00, active2}, 8'h01);
    check("opMode2", {5'h00, opMode2}, {5'h00, qsfpl_pkg::DEV_WR1});
    wrapUp();
  end
endmodule // tb_top
